/* File: prox_pkg.sv */
// Constants, register map and state types for the proximity measurement control block.
// Assumes a 40 MHz core clock and a serial slave front end that decodes byte accesses.
// Behaviour
// R01: LED pulse count per illumination phase follows the programmed integration time.
// R02: LED modulation period stays 1.5 us for every integration setting.
// R03: Integration code in config bits 2:0, reset 011, selects 150 to 4800 us.
// R04: Config bit 5 enables threshold hysteresis, reset 0; the code applies it only while auto_clear is high.
// R05: Config bit 4 picks the hysteresis threshold: 1 upper, 0 lower; reset 0.
// R06: Repeat wait is field times 10 ms plus 10 ms; 7-bit field resets to 0x04.
// R07: Control bit 1 set keeps starting cycles separated by the interval wait.
// R08: Control bit 0 triggers one cycle and clears itself when single-shot completes.
// R09: LED driver and receiver switch off as soon as each measurement ends.
// R10: Status bit 4 shows the interrupt output state, reset 0.
// R11: Without auto clear, reading status also clears the pending interrupt.
// R12: Status bit 1 flags a result above the upper limit, reset 0.
// R13: Status bit 0 flags a result below the lower limit, reset 0.
// R14: Result stored as high byte at 0x41, low byte at 0x42, reset 0x00.
// R15: Result bytes stay frozen from read start until the bus stop.
// R16: Stop ending a control write starts the next measurement cycle.
// R17: Result is lit sample minus dark sample, kept as 16 bits.
// R18: Upper-trigger hysteresis raises on upper crossing, clears on reaching lower value.
// R19: Clearing repeat lets the current cycle finish, then the block goes idle.
// R20: Don't-care bits ignore writes and read back as zero.
package prox_pkg;
  localparam int CLOCK_NS = 25;
  localparam int LED_PERIOD_NS = 1500;
  localparam int LED_HALF_CYCLES = LED_PERIOD_NS / CLOCK_NS / 2;
  localparam int SETTLE_CYCLES = 8;
  localparam int WAIT_UNIT_MS = 10;
  localparam int WAIT_UNIT_CYCLES = WAIT_UNIT_MS * 1000000 / CLOCK_NS;
  localparam int ITIME_US [8] = '{150, 300, 600, 1200, 1800, 2400, 3600, 4800};

  localparam logic [7:0] CONFIG_OFFSET = 8'h15;
  localparam logic [7:0] WAIT_OFFSET = 8'h16;
  localparam logic [7:0] CONTROL_OFFSET = 8'h17;
  localparam logic [7:0] STATUS_OFFSET = 8'h40;
  localparam logic [7:0] RESULT_HIGH_OFFSET = 8'h41;
  localparam logic [7:0] RESULT_LOW_OFFSET = 8'h42;

  localparam int ITIME_MSB = 2;
  localparam int HYST_TRIG_BIT = 4;
  localparam int HYST_EN_BIT = 5;
  localparam int WAIT_MSB = 6;
  localparam int ONESHOT_BIT = 0;
  localparam int REPEAT_BIT = 1;
  localparam int ST_LOW_BIT = 0;
  localparam int ST_HIGH_BIT = 1;
  localparam int ST_IRQ_BIT = 4;

  localparam logic [2:0] ITIME_RESET = 3'h3;
  localparam logic [6:0] WAIT_RESET = 7'h04;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  typedef enum logic [1:0] {CTL_IDLE, CTL_MEASURE, CTL_WAIT} ctl_e;
  typedef enum logic [1:0] {ENG_IDLE, ENG_SETTLE, ENG_LIT, ENG_DARK} eng_e;

  // Pulses per phase = integration time / modulation period
  function automatic logic [11:0] pulses_for(input logic [2:0] code);
    pulses_for = 12'(ITIME_US[code] * 1000 / LED_PERIOD_NS);
  endfunction : pulses_for
endpackage : prox_pkg

/* File: measure_engine.sv */
// Measurement sequencer: receiver power-up, LED modulation, lit/dark accumulation.
// Assumes sense_level is the front end's conversion, valid at the end of each half period.
`timescale 1ns/1ps
module measure_engine
  import prox_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic start,
  input wire logic [11:0] pulse_count,
  input wire logic [15:0] sense_level,
  output logic led_drive,
  output logic rx_power,
  output logic done,
  output logic [15:0] result
);
  // Delay from the second lit sample to the first dark one
  localparam int HALF_LAST = LED_HALF_CYCLES - 1;
  eng_e state;
  logic [5:0] cnt;
  logic [11:0] pulses_left;
  logic [15:0] lit_sum;
  logic [15:0] dark_sum;

  // Sequencer; sums wrap at 16 bits like the stored result
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= ENG_IDLE;
      cnt <= '0;
      pulses_left <= '0;
      lit_sum <= '0;
      dark_sum <= '0;
      led_drive <= 1'b0;
      rx_power <= 1'b0;
      done <= 1'b0;
      result <= RESULT_RESET;
    end else begin
      done <= 1'b0;
      cnt <= cnt + 6'd1;
      case (state)
        ENG_IDLE: begin
          if (start) begin
            state <= ENG_SETTLE;
            rx_power <= 1'b1;
            pulses_left <= pulse_count; // see R01
            cnt <= '0;
          end
        end
        ENG_SETTLE: begin
          if (cnt == 6'(SETTLE_CYCLES - 1)) begin
            state <= ENG_LIT;
            led_drive <= 1'b1;
            lit_sum <= '0;
            dark_sum <= '0;
            cnt <= '0;
          end
        end
        ENG_LIT: begin
          if (cnt == 6'(LED_HALF_CYCLES - 1)) begin // see R02
            lit_sum <= lit_sum + sense_level;
            led_drive <= 1'b0;
            state <= ENG_DARK;
            cnt <= '0;
          end
        end
        ENG_DARK: begin
          if (cnt == 6'(LED_HALF_CYCLES - 1)) begin
            dark_sum <= dark_sum + sense_level;
            cnt <= '0;
            pulses_left <= pulses_left - 12'd1;
            if (pulses_left <= 12'd1) begin
              // Power drops in the same edge the result lands
              result <= lit_sum - (dark_sum + sense_level); // see R17
              done <= 1'b1;
              rx_power <= 1'b0; // see R09
              state <= ENG_IDLE;
            end else begin
              led_drive <= 1'b1;
              state <= ENG_LIT;
            end
          end
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  idle_dark_a: assert property (state == ENG_IDLE |-> !led_drive && !rx_power) // see R09
    else $error("LED or receiver powered while idle");
  lit_half_a: assert property ($rose(led_drive) |-> led_drive [*2] ##HALF_LAST !led_drive) // see R02
    else $error("LED on-time is not half the modulation period");
  done_off_a: assert property (done |-> !rx_power && !led_drive && $past(rx_power)) // see R09
    else $error("Power still on when the result is delivered");
endmodule : measure_engine

/* File: proximity_measure_ctrl.sv */
// Control, status and result registers of the proximity measurement block.
// Assumes a serial slave front end that delivers byte reads, byte writes and bus stop.
`timescale 1ns/1ps
module proximity_measure_ctrl
  import prox_pkg::*;
#(
  parameter int WAIT_UNIT = WAIT_UNIT_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic read_begin,
  input wire logic bus_stop,
  input wire logic auto_clear,
  input wire logic [15:0] upper_limit,
  input wire logic [15:0] lower_limit,
  input wire logic [15:0] sense_level,
  output logic [7:0] reg_rdata,
  output logic irq_out,
  output logic led_drive,
  output logic rx_power
);
  if (WAIT_UNIT < 1 || WAIT_UNIT > 2 ** 30) begin : bad_wait_unit
    $error("WAIT_UNIT must lie between 1 and 2**30");
  end

  logic [2:0] itime;
  logic hyst_en;
  logic hyst_trig;
  logic [6:0] wait_val;
  logic single_run;
  logic continuous_run;
  logic ctrl_written;
  logic high_crossing_flag;
  logic low_crossing_flag;
  logic [15:0] proximity_result;
  logic [15:0] pending_result;
  logic pending_valid;
  logic locked;
  ctl_e state;
  logic [29:0] unit_cnt;
  logic [6:0] slot_cnt;
  logic eng_start;
  logic eng_done;
  logic [15:0] eng_result;
  logic ctrl_wr;
  logic status_rd;
  logic rd_clear;
  logic above;
  logic below;

  // Access decode
  assign ctrl_wr = reg_wr && reg_addr == CONTROL_OFFSET;
  assign status_rd = reg_rd && reg_addr == STATUS_OFFSET;
  assign rd_clear = status_rd && !auto_clear;
  assign above = eng_result > upper_limit;
  assign below = eng_result < lower_limit;

  // Configuration and interval; unused bits dropped on write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      itime <= ITIME_RESET; // see R03
      hyst_en <= 1'b0;
      hyst_trig <= 1'b0;
      wait_val <= WAIT_RESET; // see R06
    end else if (reg_wr && reg_addr == CONFIG_OFFSET) begin
      itime <= reg_wdata[ITIME_MSB:0]; // see R20
      hyst_en <= reg_wdata[HYST_EN_BIT]; // see R04
      hyst_trig <= reg_wdata[HYST_TRIG_BIT]; // see R05
    end else if (reg_wr && reg_addr == WAIT_OFFSET) begin
      wait_val <= reg_wdata[WAIT_MSB:0];
    end
  end

  // Control bits; a host write in the completion cycle overrides the self-clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      single_run <= 1'b0;
      continuous_run <= 1'b0;
    end else if (ctrl_wr) begin
      single_run <= reg_wdata[ONESHOT_BIT];
      continuous_run <= reg_wdata[REPEAT_BIT];
    end else if (eng_done && !continuous_run) begin
      single_run <= 1'b0; // see R08
    end
  end

  // Remember a control write until the stop that closes it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_written <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_written <= 1'b1;
    end else if (bus_stop) begin
      ctrl_written <= 1'b0;
    end
  end

  // Interval timer: (wait_val + 1) units of 10 ms
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      unit_cnt <= '0;
      slot_cnt <= '0;
    end else if (state != CTL_WAIT) begin
      unit_cnt <= '0;
      slot_cnt <= '0;
    end else if (unit_cnt == 30'(WAIT_UNIT - 1)) begin
      unit_cnt <= '0;
      slot_cnt <= slot_cnt + 7'd1;
    end else begin
      unit_cnt <= unit_cnt + 30'd1;
    end
  end

  // Sequencing of cycles; engine start is a one-cycle request
  always_comb begin
    eng_start = 1'b0;
    case (state)
      CTL_IDLE: eng_start = bus_stop && ctrl_written && (single_run || continuous_run); // see R16
      CTL_WAIT: eng_start = continuous_run && slot_cnt == wait_val && unit_cnt == 30'(WAIT_UNIT - 1); // see R06
      default: eng_start = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= CTL_IDLE;
    end else begin
      case (state)
        CTL_IDLE: begin
          if (eng_start) begin
            state <= CTL_MEASURE;
          end
        end
        CTL_MEASURE: begin
          if (eng_done) begin
            state <= continuous_run ? CTL_WAIT : CTL_IDLE; // see R07
          end
        end
        CTL_WAIT: begin
          if (!continuous_run) begin
            state <= CTL_IDLE; // see R19
          end else if (eng_start) begin
            state <= CTL_MEASURE; // see R07
          end
        end
        default: state <= CTL_IDLE;
      endcase
    end
  end

  measure_engine engine (
    .clock(clock),
    .nrst(nrst),
    .start(eng_start),
    .pulse_count(pulses_for(itime)),
    .sense_level(sense_level),
    .led_drive(led_drive),
    .rx_power(rx_power),
    .done(eng_done),
    .result(eng_result)
  );

  // Read lock: held from read start to stop
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      locked <= 1'b0;
    end else if (read_begin) begin
      locked <= 1'b1; // see R15
    end else if (bus_stop) begin
      locked <= 1'b0;
    end
  end

  // Result store; a result finishing under lock waits in a holding register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      proximity_result <= RESULT_RESET; // see R14
      pending_result <= RESULT_RESET;
      pending_valid <= 1'b0;
    end else if (eng_done) begin
      if (locked || read_begin) begin
        pending_result <= eng_result; // see R15
        pending_valid <= 1'b1;
      end else begin
        proximity_result <= eng_result;
        pending_valid <= 1'b0;
      end
    end else if (pending_valid && !locked && !read_begin) begin
      proximity_result <= pending_result;
      pending_valid <= 1'b0;
    end
  end

  // Interrupt state; a crossing in the read-clear cycle is kept
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_out <= 1'b0;
      high_crossing_flag <= 1'b0;
      low_crossing_flag <= 1'b0;
    end else if (eng_done && auto_clear && hyst_en) begin
      if (hyst_trig) begin
        if (above) begin
          irq_out <= 1'b1; // see R18
          high_crossing_flag <= 1'b1;
        end else if (eng_result <= lower_limit) begin
          irq_out <= 1'b0; // see R18
          high_crossing_flag <= 1'b0;
          low_crossing_flag <= 1'b0;
        end
      end else begin
        if (below) begin
          irq_out <= 1'b1;
          low_crossing_flag <= 1'b1;
        end else if (eng_result >= upper_limit) begin
          irq_out <= 1'b0;
          high_crossing_flag <= 1'b0;
          low_crossing_flag <= 1'b0;
        end
      end
    end else if (eng_done && auto_clear) begin
      irq_out <= above || below;
      high_crossing_flag <= above; // see R12
      low_crossing_flag <= below; // see R13
    end else if (eng_done) begin
      irq_out <= (irq_out && !rd_clear) || above || below;
      high_crossing_flag <= (high_crossing_flag && !rd_clear) || above; // see R12
      low_crossing_flag <= (low_crossing_flag && !rd_clear) || below; // see R13
    end else if (rd_clear) begin
      irq_out <= 1'b0; // see R11
      high_crossing_flag <= 1'b0;
      low_crossing_flag <= 1'b0;
    end
  end

  // Read data, loaded on the read strobe; unused bits read zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        CONFIG_OFFSET: reg_rdata <= {2'b00, hyst_en, hyst_trig, 1'b0, itime}; // see R20
        WAIT_OFFSET: reg_rdata <= {1'b0, wait_val};
        CONTROL_OFFSET: reg_rdata <= {6'h00, continuous_run, single_run};
        STATUS_OFFSET: reg_rdata <= {3'h0, irq_out, 2'h0, high_crossing_flag, low_crossing_flag}; // see R10
        RESULT_HIGH_OFFSET: reg_rdata <= proximity_result[15:8]; // see R14
        RESULT_LOW_OFFSET: reg_rdata <= proximity_result[7:0];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence status_read_s;
    reg_rd && reg_addr == STATUS_OFFSET;
  endsequence
  sequence quiet_done_s;
    eng_done && !continuous_run && !ctrl_wr;
  endsequence

  oneshot_clear_a: assert property (quiet_done_s |=> !single_run) // see R08
    else $error("Single-run bit did not clear after the cycle");
  status_irq_a: assert property (status_read_s |=> reg_rdata[ST_IRQ_BIT] == $past(irq_out)) // see R10
    else $error("Status bit 4 differs from the interrupt output");
  read_clear_a: assert property (status_read_s ##0 (!auto_clear && !eng_done) |=> !irq_out) // see R11
    else $error("Status read did not clear the interrupt");
  lock_hold_a: assert property (locked && !bus_stop |=> $stable(proximity_result)) // see R15
    else $error("Result changed while locked for a read");
  stop_start_a: assert property (state == CTL_IDLE && bus_stop && ctrl_written && single_run
                                 |=> state == CTL_MEASURE ##1 rx_power) // see R16
    else $error("Stop after control write did not start a cycle");
  repeat_halt_a: assert property (state == CTL_WAIT && !continuous_run |=> state == CTL_IDLE) // see R19
    else $error("Repeat cleared but block did not go idle");
  repeat_wait_a: assert property (eng_done && continuous_run && !ctrl_wr |=> state == CTL_WAIT [*2]) // see R07
    else $error("Repeat cycle did not enter the interval wait");
  hyst_up_a: assert property (eng_done && auto_clear && hyst_en && hyst_trig && eng_result > upper_limit
                              |=> irq_out && high_crossing_flag) // see R18
    else $error("Upper crossing did not raise the interrupt");

  // A result that lands with no read open
  sequence free_done_s;
    eng_done && !locked && !read_begin;
  endsequence

  result_load_a: assert property (free_done_s |=> proximity_result == $past(eng_result)) // see R14
    else $error("Finished result was not stored");
  pending_apply_a: assert property (pending_valid && !locked && !read_begin && !eng_done
                                    |=> !pending_valid && proximity_result == $past(pending_result)) // see R15
    else $error("Held result not applied after the stop");
  sticky_high_a: assert property (eng_done && !auto_clear && above |=> irq_out && high_crossing_flag) // see R12
    else $error("Upper crossing flag not set");
  sticky_low_a: assert property (eng_done && !auto_clear && below |=> irq_out && low_crossing_flag) // see R13
    else $error("Lower crossing flag not set");
  hyst_down_a: assert property (eng_done && auto_clear && hyst_en && hyst_trig && !above
                                && eng_result <= lower_limit |=> !irq_out && !high_crossing_flag) // see R18
    else $error("Hysteresis did not clear at the lower value");
  busy_refuse_a: assert property (state == CTL_MEASURE && bus_stop && !eng_done |=> state == CTL_MEASURE) // see R16
    else $error("Stop during a measurement changed the sequence");
  config_write_a: assert property (reg_wr && reg_addr == CONFIG_OFFSET |=> itime == $past(reg_wdata[ITIME_MSB:0])) // see R03
    else $error("Integration code not taken from the write");
endmodule : proximity_measure_ctrl

/* File: front_end_model.sv */
// Stand-in for the reflected-light front end that feeds the measurement block.
// Assumes the block samples sense_level only while its receiver is powered.
`timescale 1ns/1ps
module front_end_model (
  input wire logic clock,
  input wire logic led_drive,
  input wire logic rx_power,
  input wire logic [15:0] lit_level,
  input wire logic [15:0] dark_level,
  output logic [15:0] sense_level
);
  logic [15:0] noise = 16'h5A5A;

  // Unpowered receiver gives a moving pattern, so a stale level is never read as valid
  always @(posedge clock) begin
    noise <= ~noise + 16'h0001;
  end

  // Lit and ambient levels follow the LED state
  always_comb begin
    sense_level = !rx_power ? noise : (led_drive ? lit_level : dark_level);
  end
endmodule : front_end_model

/* File: proximity_measure_ctrl_test.sv */
// Self-checking bench for the proximity measurement control block.
// Assumes the front end model beside it; host accesses are driven on the byte port.
`timescale 1ns/1ps
module proximity_measure_ctrl_test;
  import prox_pkg::*;
  localparam int UNIT = 20;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic read_begin = 1'b0;
  logic bus_stop = 1'b0;
  logic auto_clear = 1'b0;
  logic [15:0] upper_limit = 16'hFFFF;
  logic [15:0] lower_limit = 16'h0000;
  logic [15:0] lit = 16'h0000;
  logic [15:0] dark = 16'h0000;
  logic [15:0] sense_level;
  logic [7:0] reg_rdata;
  logic irq_out;
  logic led_drive;
  logic rx_power;
  logic rd_seen = 1'b0;
  logic led_last = 1'b0;
  logic hit = 1'b0;
  logic [15:0] res_now = 16'h0000;
  logic [7:0] exp_q[$];
  int fails = 0;
  int cmp_count = 0;
  int pulse_cnt = 0;
  int hi_len = 0;
  int n = 0;

  initial begin
    forever #12.5 clock = ~clock;
  end

  proximity_measure_ctrl #(.WAIT_UNIT(UNIT)) i_proximity_measure_ctrl (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .read_begin(read_begin), .bus_stop(bus_stop), .auto_clear(auto_clear),
    .upper_limit(upper_limit), .lower_limit(lower_limit), .sense_level(sense_level),
    .reg_rdata(reg_rdata), .irq_out(irq_out), .led_drive(led_drive), .rx_power(rx_power));

  front_end_model i_front_end_model (
    .clock(clock), .led_drive(led_drive), .rx_power(rx_power),
    .lit_level(lit), .dark_level(dark), .sense_level(sense_level));

  task automatic tally_and_finish;
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Read data is due one cycle after the strobe; the oldest note is the match
  always @(posedge clock) begin
    if (rd_seen) begin
      chk({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
    end
    rd_seen <= reg_rd;
  end

  // LED on-time per pulse and pulse count per measurement
  always @(posedge clock) begin
    led_last <= led_drive;
    if (led_drive) begin
      hi_len <= hi_len + 1;
    end else if (led_last) begin
      pulse_cnt <= pulse_cnt + 1;
      chk(16'(hi_len), 16'(LED_HALF_CYCLES));
      hi_len <= 0;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // Extra edge lets read side effects settle before the next step
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask : rd

  // 0 gives a bus stop, 1 a read start
  task automatic strobe(input bit which);
    @(posedge clock);
    if (which) read_begin <= 1'b1;
    else bus_stop <= 1'b1;
    @(posedge clock);
    read_begin <= 1'b0;
    bus_stop <= 1'b0;
  endtask : strobe

  // Checked at the falling edge so design updates have landed
  task automatic wait_rx(input logic v, input int bound);
    n = 0;
    while (rx_power !== v && n < bound) begin
      @(negedge clock);
      n++;
    end
    if (n >= bound) begin
      fails++;
      tally_and_finish();
    end
  endtask : wait_rx

  task automatic one_shot(input logic [7:0] cfg, input bit lock);
    int pulses;
    logic [15:0] old;
    pulses = ITIME_US[cfg[ITIME_MSB:0]] * 1000 / 1500;
    old = res_now;
    lit <= 16'($urandom_range(1023, 256));
    dark <= 16'($urandom_range(255, 0));
    wr(CONFIG_OFFSET, cfg);
    pulse_cnt = 0;
    wr(CONTROL_OFFSET, 8'h01);
    strobe(1'b0);
    wait_rx(1'b1, 20);
    if (lock) strobe(1'b1);
    wait_rx(1'b0, 30000);
    res_now = 16'(pulses * (lit - dark));
    chk(16'(pulse_cnt), 16'(pulses));
    chk({15'h0000, led_drive}, 16'h0000);
    if (lock) begin
      rd(RESULT_HIGH_OFFSET, old[15:8]);
      rd(RESULT_LOW_OFFSET, old[7:0]);
      strobe(1'b0);
    end
    rd(CONTROL_OFFSET, 8'h00);
    rd(RESULT_HIGH_OFFSET, res_now[15:8]);
    rd(RESULT_LOW_OFFSET, res_now[7:0]);
  endtask : one_shot

  // Main sequence
  initial begin
    void'($urandom(10));
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    // Reset values and unmapped space
    rd(CONFIG_OFFSET, 8'h03);
    rd(WAIT_OFFSET, 8'h04);
    rd(CONTROL_OFFSET, 8'h00);
    rd(STATUS_OFFSET, 8'h00);
    rd(RESULT_HIGH_OFFSET, 8'h00);
    rd(RESULT_LOW_OFFSET, 8'h00);
    rd(8'h20, 8'h00);
    // Every integration code reads back; don't-care bits drop out
    for (int c = 0; c < 8; c++) begin
      wr(CONFIG_OFFSET, 8'hC8 | 8'(c));
      rd(CONFIG_OFFSET, 8'(c));
    end
    wr(CONFIG_OFFSET, 8'hFF);
    rd(CONFIG_OFFSET, 8'h37);
    wr(WAIT_OFFSET, 8'hFF);
    rd(WAIT_OFFSET, 8'h7F);
    wr(STATUS_OFFSET, 8'hFF);
    rd(STATUS_OFFSET, 8'h00);
    // Single runs over three integration codes, limits out of reach
    for (int c = 0; c < 3; c++) begin
      one_shot(8'(c), 1'b0);
    end
    rd(STATUS_OFFSET, 8'h00);
    // Upper crossing stays until the status read, during a locked read
    upper_limit <= 16'h0000;
    one_shot(8'h00, 1'b1);
    chk({15'h0000, irq_out}, 16'h0001);
    rd(STATUS_OFFSET, 8'h12);
    chk({15'h0000, irq_out}, 16'h0000);
    rd(STATUS_OFFSET, 8'h00);
    // Lower crossing
    lower_limit <= 16'hFFFF;
    upper_limit <= 16'hFFFF;
    one_shot(8'h00, 1'b0);
    rd(STATUS_OFFSET, 8'h11);
    // Auto clear with upper-trigger hysteresis: reads keep it, only the lower value clears it
    auto_clear <= 1'b1;
    upper_limit <= 16'h0000;
    one_shot(8'h30, 1'b0);
    rd(STATUS_OFFSET, 8'h12);
    rd(STATUS_OFFSET, 8'h12);
    chk({15'h0000, irq_out}, 16'h0001);
    upper_limit <= 16'hFFFF;
    one_shot(8'h30, 1'b0);
    rd(STATUS_OFFSET, 8'h00);
    // Repeat with a two-unit wait, then stop during the second cycle
    lower_limit <= 16'h0000;
    wr(WAIT_OFFSET, 8'h01);
    wr(CONTROL_OFFSET, 8'h02);
    strobe(1'b0);
    wait_rx(1'b1, 20);
    wait_rx(1'b0, 30000);
    wait_rx(1'b1, 1000);
    pulse_cnt = 0;
    chk(16'(n >= 2 * UNIT - 1 && n <= 2 * UNIT + 3), 16'h0001);
    rd(CONTROL_OFFSET, 8'h02);
    wr(CONTROL_OFFSET, 8'h00);
    strobe(1'b0);
    // The cycle in progress must still run all its pulses
    wait_rx(1'b0, 30000);
    chk(16'(pulse_cnt), 16'(ITIME_US[0] * 1000 / 1500));
    repeat (300) begin
      @(negedge clock);
      if (rx_power !== 1'b0) hit = 1'b1;
    end
    chk({15'h0000, hit}, 16'h0000);
    tally_and_finish();
  end
endmodule : proximity_measure_ctrl_test
